// [src/icgr_pkg.sv]
/*
 * Constants of the clock generator register block: register indices,
 * control bit positions, reset values and timing counts.
 * Assumes a 200 MHz bus clock and word-aligned AHB-Lite access.
 */
package icgr_pkg;

  // Bus clock
  localparam int unsigned CLK_HZ = 200_000_000;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONTROL = 6'h36;
  localparam logic [5:0] IDX_MULT = 6'h37;
  localparam logic [5:0] IDX_TRIM = 6'h38;
  localparam logic [5:0] IDX_DIVIDER = 6'h39;
  localparam logic [5:0] IDX_STAGE = 6'h3a;

  // Control register bit positions
  localparam int unsigned BIT_IRQ_EN = 7;
  localparam int unsigned BIT_MON_FLAG = 6;
  localparam int unsigned BIT_MON_ON = 5;
  localparam int unsigned BIT_CLK_SEL = 4;
  localparam int unsigned BIT_INT_ON = 3;
  localparam int unsigned BIT_INT_STABLE = 2;
  localparam int unsigned BIT_EXT_ON = 1;
  localparam int unsigned BIT_EXT_STABLE = 0;

  // Reset values
  localparam logic [6:0] MULT_RESET = 7'h15;
  localparam logic [7:0] TRIM_RESET = 8'h80;

  // Halving count limits
  localparam logic [3:0] HALVING_MAX = 4'h9;

  // External startup delay in external clock edges
  localparam logic [12:0] EXT_STABLE_EDGES = 13'h1000;

  // Base clock and slowest slow-crystal clock
  localparam int unsigned BASE_FREQ_HZ = 307_200;
  localparam int unsigned SLOW_MIN_FREQ_HZ = 60;

  // Inactivity timeouts: one period of the limit clock, rounded up
  localparam int unsigned TO_W = 22;
  localparam logic [TO_W-1:0] FAST_TIMEOUT_CYC =
    TO_W'((CLK_HZ + BASE_FREQ_HZ - 1) / BASE_FREQ_HZ);
  localparam int unsigned SLOW_TIMEOUT_CYC =
    (CLK_HZ + SLOW_MIN_FREQ_HZ - 1) / SLOW_MIN_FREQ_HZ;

  // Hold-off of the internal stable bit after a frequency change
  localparam int unsigned RELOCK_NS = 80;
  localparam logic [4:0] RELOCK_CYC = 5'(RELOCK_NS / 5);

endpackage : icgr_pkg

// [src/icgr_clk_activity.sv]
/*
 * Activity detector for one oscillator clock seen from the bus clock.
 * Assumes the watched clock is asynchronous and well below hclk / 2.
 */
`timescale 1ns/1ps
module icgr_clk_activity #(
  parameter int unsigned TW = 22
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic watched_clk,
  input wire logic enable,
  input wire logic [TW-1:0] timeout,
  output logic clk_level,
  output logic edge_pulse,
  output logic inactive
);

  logic sync1_q;
  logic sync2_q;
  logic last_q;
  logic [TW-1:0] idle_cnt_q;

  // Two-stage synchroniser and edge history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      sync1_q <= watched_clk;
      sync2_q <= sync1_q;
      last_q <= sync2_q;
    end
  end

  assign clk_level = sync2_q;
  assign edge_pulse = sync2_q & ~last_q;

  // Cycles since the last rising edge; saturates at the timeout
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt_q <= '0;
      inactive <= 1'b0;
    end else if (!enable || edge_pulse) begin
      idle_cnt_q <= '0;
      inactive <= 1'b0;
    end else if (idle_cnt_q >= timeout) begin
      inactive <= 1'b1;
    end else begin
      idle_cnt_q <= idle_cnt_q + 1'b1;
    end
  end

endmodule : icgr_clk_activity

// [src/icgr_top.sv]
/*
 * Control and status registers of the on-chip clock generator, with the
 * oscillator interlocks, clock monitor and clock selection, on AHB-Lite.
 * Assumes the oscillators, loop filter and config option live outside;
 * oscillator clocks and the lock indication arrive asynchronously.
 */
// What this block does
// - Interrupt request when enable and flag set
// - Irq enable settable after monitor on; else cleared
// - Flag sets on clock inactivity while monitoring
// - Flag clears by read-then-write-zero; forced off
// - Monitor on needs both oscillators on, stable
// - Flag forces monitor on; oscillator off clears
// - Select picks external (1) or internal (0)
// - Select changes need target oscillator ready
// - Dead or off oscillator forces select away
// - Internal enable clear needs select, no monitor
// - Internal stable from lock; several forced clears
// - External enable clear needs select, monitor clear
// - External stable after 4096 external edges
// - Multiplier factor zero behaves as one
// - Multiplier and trim locked while monitoring
// - Reset loads multiplier 21, trim 80 hex
// - Trim step moves frequency about 0.195 percent
// - Halving count clamps at nine; survives reset
// - Loop filter owns divider fields while running
// - Stage count adds stages; survives reset
// - Slow crystal option lengthens external timeout
// - Stop mode holds output clocks low
`timescale 1ns/1ps
module icgr_top
  import icgr_pkg::*;
#(
  parameter int unsigned SLOW_TIMEOUT = icgr_pkg::SLOW_TIMEOUT_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic internal_clock,
  input wire logic external_clock,
  input wire logic int_within_tol,
  input wire logic slow_crystal_option,
  input wire logic stop_mode,
  input wire logic lf_update,
  input wire logic [3:0] lf_halving_count,
  input wire logic [7:0] lf_stage_count,
  output logic osc_out_clock,
  output logic core_out_clock,
  output logic clk_mon_irq,
  output logic int_osc_enable,
  output logic ext_osc_enable,
  output logic [6:0] multiplier_factor,
  output logic [7:0] cap_adjust_factor,
  output logic [3:0] dco_halving_count,
  output logic [7:0] dco_stage_count
);
  import icgr_pkg::*;

  // Control bits
  logic clk_mon_irq_en_q, clk_mon_flag_q, clk_mon_on_q, clk_sel_q;
  logic int_osc_on_q, int_osc_stable_q, ext_osc_on_q, ext_osc_stable_q;
  logic clk_mon_irq_en_d, clk_mon_flag_d, clk_mon_on_d, clk_sel_d;
  logic int_osc_on_d, int_osc_stable_d, ext_osc_on_d;
  // Data registers
  logic [6:0] mult_q;
  logic [7:0] trim_q;
  logic [3:0] halving_q;
  logic [7:0] stage_q;
  // Bus state
  logic wr_pend_q, rd_pend_q;
  logic [5:0] idx_q;
  logic mapped_q;
  // Previous-cycle copies of the held conditions
  logic mon_on_prev_q, all_ok_prev_q, ext_ok_prev_q, int_ok_prev_q;
  logic int_off_ok_prev_q, ext_off_ok_prev_q;
  // Flag clear sequencing, stable tracking
  logic flag_armed_q;
  logic [12:0] ext_edges_q;
  logic [4:0] relock_q;
  logic tol_sync1_q, tol_sync2_q;
  logic core_div_q;
  logic prev_sel_level_q;

  logic int_level, int_dead;
  logic ext_level, ext_edge, ext_dead;
  logic [TO_W-1:0] ext_timeout;
  logic addr_ok, wr_now;
  logic wr_ctrl, wr_mult, wr_trim, wr_div, wr_stage;
  logic [7:0] wd;
  logic [7:0] ctrl_rd;
  logic [7:0] rd_mux;
  logic sel_level;

  // Timeout of the external monitor follows the crystal option
  assign ext_timeout = slow_crystal_option ? TO_W'(SLOW_TIMEOUT) : FAST_TIMEOUT_CYC;

  // Activity monitors, idle in stop mode or while the oscillator is off
  icgr_clk_activity #(.TW(TO_W)) u_int_mon (
    .hclk(hclk),
    .hresetn(hresetn),
    .watched_clk(internal_clock),
    .enable(int_osc_on_q & ~stop_mode),
    .timeout(FAST_TIMEOUT_CYC),
    .clk_level(int_level),
    .edge_pulse(),
    .inactive(int_dead)
  );

  icgr_clk_activity #(.TW(TO_W)) u_ext_mon (
    .hclk(hclk),
    .hresetn(hresetn),
    .watched_clk(external_clock),
    .enable(ext_osc_on_q & ~stop_mode),
    .timeout(ext_timeout),
    .clk_level(ext_level),
    .edge_pulse(ext_edge),
    .inactive(ext_dead)
  );

  // Address phase decode
  assign addr_ok = hsel & hready & htrans[1];

  // Data phase write strobes
  assign wr_now = wr_pend_q & mapped_q;
  assign wd = hwdata[7:0];

  // Register select
  always_comb begin
    wr_ctrl = 1'b0;
    wr_mult = 1'b0;
    wr_trim = 1'b0;
    wr_div = 1'b0;
    wr_stage = 1'b0;
    if (wr_now && idx_q == IDX_CONTROL) begin
      wr_ctrl = 1'b1;
    end else if (wr_now && idx_q == IDX_MULT) begin
      wr_mult = 1'b1;
    end else if (wr_now && idx_q == IDX_TRIM) begin
      wr_trim = 1'b1;
    end else if (wr_now && idx_q == IDX_DIVIDER) begin
      wr_div = 1'b1;
    end else if (wr_now && idx_q == IDX_STAGE) begin
      wr_stage = 1'b1;
    end
  end

  // AHB-Lite slave: writes take no wait, reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q <= '0;
      mapped_q <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= '0;
    end else if (rd_pend_q) begin
      rd_pend_q <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= {24'h000000, mapped_q ? rd_mux : 8'h00};
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      rd_pend_q <= addr_ok & ~hwrite;
      hreadyout <= ~(addr_ok & ~hwrite);
      if (addr_ok) begin
        idx_q <= haddr[7:2];
        mapped_q <= (haddr[31:8] == 24'h000000) && (haddr[7:2] >= IDX_CONTROL)
                    && (haddr[7:2] <= IDX_STAGE);
      end
    end
  end

  // Read data; reserved bits read zero
  assign ctrl_rd = {clk_mon_irq_en_q, clk_mon_flag_q, clk_mon_on_q, clk_sel_q,
                    int_osc_on_q, int_osc_stable_q, ext_osc_on_q, ext_osc_stable_q};
  always_comb begin
    rd_mux = 8'h00;
    if (idx_q == IDX_CONTROL) begin
      rd_mux = ctrl_rd;
    end else if (idx_q == IDX_MULT) begin
      rd_mux = {1'b0, mult_q};
    end else if (idx_q == IDX_TRIM) begin
      rd_mux = trim_q;
    end else if (idx_q == IDX_DIVIDER) begin
      rd_mux = {4'h0, halving_q};
    end else if (idx_q == IDX_STAGE) begin
      rd_mux = stage_q;
    end
  end

  // Registered copies of conditions, tested one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mon_on_prev_q <= 1'b0;
      all_ok_prev_q <= 1'b0;
      ext_ok_prev_q <= 1'b0;
      int_ok_prev_q <= 1'b0;
      int_off_ok_prev_q <= 1'b0;
      ext_off_ok_prev_q <= 1'b0;
    end else begin
      mon_on_prev_q <= clk_mon_on_q;
      all_ok_prev_q <= int_osc_on_q & ext_osc_on_q & int_osc_stable_q & ext_osc_stable_q;
      ext_ok_prev_q <= ext_osc_on_q & ext_osc_stable_q;
      int_ok_prev_q <= int_osc_on_q & int_osc_stable_q;
      int_off_ok_prev_q <= clk_sel_q & ~clk_mon_on_q;
      ext_off_ok_prev_q <= ~clk_sel_q & ~clk_mon_on_q;
    end
  end

  // Interlocks among the control bits; forces act on present state
  always_comb begin
    clk_mon_irq_en_d = clk_mon_irq_en_q;
    clk_mon_on_d = clk_mon_on_q;
    clk_sel_d = clk_sel_q;
    int_osc_on_d = int_osc_on_q;
    ext_osc_on_d = ext_osc_on_q;
    clk_mon_flag_d = clk_mon_flag_q;
    if (wr_ctrl) begin
      if (!wd[BIT_IRQ_EN]) begin
        clk_mon_irq_en_d = 1'b0;
      end else if (mon_on_prev_q && clk_mon_on_q) begin
        clk_mon_irq_en_d = 1'b1;
      end
      if (!wd[BIT_MON_ON]) begin
        clk_mon_on_d = 1'b0;
      end else if (all_ok_prev_q && int_osc_on_q && ext_osc_on_q
                   && int_osc_stable_q && ext_osc_stable_q) begin
        clk_mon_on_d = 1'b1;
      end
      if (wd[BIT_CLK_SEL] && ext_ok_prev_q && ext_osc_on_q && ext_osc_stable_q) begin
        clk_sel_d = 1'b1;
      end else if (!wd[BIT_CLK_SEL] && int_ok_prev_q && int_osc_on_q
                   && int_osc_stable_q) begin
        clk_sel_d = 1'b0;
      end
      if (wd[BIT_INT_ON]) begin
        int_osc_on_d = 1'b1;
      end else if (int_off_ok_prev_q && clk_sel_q && !clk_mon_on_q) begin
        int_osc_on_d = 1'b0;
      end
      if (wd[BIT_EXT_ON]) begin
        ext_osc_on_d = 1'b1;
      end else if (ext_off_ok_prev_q && !clk_sel_q && !clk_mon_on_q) begin
        ext_osc_on_d = 1'b0;
      end
      if (!wd[BIT_MON_FLAG] && flag_armed_q) begin
        clk_mon_flag_d = 1'b0;
      end
    end
    // Flag set wins over its clear
    if (clk_mon_on_q && (int_dead || ext_dead)) begin
      clk_mon_flag_d = 1'b1;
    end
    if (!clk_mon_on_q) begin
      clk_mon_flag_d = 1'b0;
    end
    if (clk_mon_flag_q) begin
      clk_mon_on_d = 1'b1;
    end
    if (!int_osc_on_q || !ext_osc_on_q) begin
      clk_mon_on_d = 1'b0;
    end
    if (!clk_mon_on_q) begin
      clk_mon_irq_en_d = 1'b0;
    end
    if (int_dead || !int_osc_on_q) begin
      clk_sel_d = 1'b1;
    end
    if (ext_dead || !ext_osc_on_q) begin
      clk_sel_d = 1'b0;
    end
    if (clk_mon_on_q || !clk_sel_q) begin
      int_osc_on_d = 1'b1;
    end
    if (clk_mon_on_q || clk_sel_q) begin
      ext_osc_on_d = 1'b1;
    end
  end

  // Control bit storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_mon_irq_en_q <= 1'b0;
      clk_mon_flag_q <= 1'b0;
      clk_mon_on_q <= 1'b0;
      clk_sel_q <= 1'b0;
      int_osc_on_q <= 1'b1;
      ext_osc_on_q <= 1'b0;
    end else begin
      clk_mon_irq_en_q <= clk_mon_irq_en_d;
      clk_mon_flag_q <= clk_mon_flag_d;
      clk_mon_on_q <= clk_mon_on_d;
      clk_sel_q <= clk_sel_d;
      int_osc_on_q <= int_osc_on_d;
      ext_osc_on_q <= ext_osc_on_d;
    end
  end

  // Flag clear is armed by a control read that sees the flag set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_armed_q <= 1'b0;
    end else if (!clk_mon_flag_q || wr_ctrl) begin
      flag_armed_q <= 1'b0;
    end else if (rd_pend_q && mapped_q && idx_q == IDX_CONTROL) begin
      flag_armed_q <= 1'b1;
    end
  end

  // Lock indication synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tol_sync1_q <= 1'b0;
      tol_sync2_q <= 1'b0;
    end else begin
      tol_sync1_q <= int_within_tol;
      tol_sync2_q <= tol_sync1_q;
    end
  end

  // Internal stable: follows lock after a hold-off on frequency writes
  always_comb begin
    int_osc_stable_d = tol_sync2_q && relock_q == 5'd0;
    if (!int_osc_on_q || int_dead || wr_mult || wr_trim) begin
      int_osc_stable_d = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_osc_stable_q <= 1'b0;
      relock_q <= '0;
    end else begin
      int_osc_stable_q <= int_osc_stable_d;
      if ((wr_mult || wr_trim) && !clk_mon_on_q) begin
        relock_q <= RELOCK_CYC;
      end else if (relock_q != 5'd0) begin
        relock_q <= relock_q - 5'd1;
      end
    end
  end

  // External stable after the startup count of external edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_edges_q <= '0;
      ext_osc_stable_q <= 1'b0;
    end else if (!ext_osc_on_q || ext_dead) begin
      ext_edges_q <= '0;
      ext_osc_stable_q <= 1'b0;
    end else if (ext_edge && !ext_osc_stable_q) begin
      ext_edges_q <= ext_edges_q + 13'd1;
      ext_osc_stable_q <= (ext_edges_q + 13'd1) == EXT_STABLE_EDGES;
    end
  end

  // Multiplier and trim, locked while the monitor runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mult_q <= MULT_RESET;
      trim_q <= TRIM_RESET;
    end else if (!clk_mon_on_q) begin
      if (wr_mult) begin
        mult_q <= wd[6:0];
      end
      if (wr_trim) begin
        trim_q <= wd;
      end
    end
  end

  // Divider fields keep their value through reset
  always_ff @(posedge hclk) begin
    if (int_osc_on_q) begin
      if (lf_update) begin
        halving_q <= lf_halving_count;
        stage_q <= lf_stage_count;
      end
    end else begin
      if (wr_div) begin
        halving_q <= wd[3:0];
      end
      if (wr_stage) begin
        stage_q <= wd;
      end
    end
  end

  // Oscillator-facing settings, registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      multiplier_factor <= MULT_RESET;
      cap_adjust_factor <= TRIM_RESET;
      int_osc_enable <= 1'b1;
      ext_osc_enable <= 1'b0;
    end else begin
      multiplier_factor <= (mult_q == 7'h00) ? 7'h01 : mult_q;
      cap_adjust_factor <= trim_q;
      int_osc_enable <= int_osc_on_q & ~stop_mode;
      ext_osc_enable <= ext_osc_on_q & ~stop_mode;
    end
  end

  // Divider outputs share the divider registers' lack of reset
  always_ff @(posedge hclk) begin
    dco_halving_count <= (halving_q > HALVING_MAX) ? HALVING_MAX : halving_q;
    dco_stage_count <= stage_q;
  end

  // Clock selection and output clocks
  assign sel_level = clk_sel_q ? ext_level : int_level;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_out_clock <= 1'b0;
      core_out_clock <= 1'b0;
      core_div_q <= 1'b0;
      prev_sel_level_q <= 1'b0;
    end else if (stop_mode) begin
      osc_out_clock <= 1'b0;
      core_out_clock <= 1'b0;
      core_div_q <= 1'b0;
    end else begin
      prev_sel_level_q <= sel_level;
      osc_out_clock <= sel_level;
      if (sel_level && !prev_sel_level_q) begin
        core_div_q <= ~core_div_q;
      end
      core_out_clock <= core_div_q;
    end
  end

  // Monitor interrupt request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_mon_irq <= 1'b0;
    end else begin
      clk_mon_irq <= clk_mon_irq_en_q & clk_mon_flag_q;
    end
  end

endmodule : icgr_top

// [tb/icgr_top_asserts.sv]
/*
 * Checker for the clock generator register block, bound to icgr_top.
 * Assumes one bus clock domain and an AHB-Lite slave with hready tied back.
 */
`timescale 1ns/1ps
module icgr_top_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic stop_mode,
  input wire logic lf_update,
  input wire logic [3:0] lf_halving_count,
  input wire logic [7:0] lf_stage_count,
  input wire logic osc_out_clock,
  input wire logic core_out_clock,
  input wire logic clk_mon_irq,
  input wire logic int_osc_enable,
  input wire logic ext_osc_enable,
  input wire logic [6:0] multiplier_factor,
  input wire logic [7:0] cap_adjust_factor,
  input wire logic [3:0] dco_halving_count,
  input wire logic [7:0] dco_stage_count
);
  // Everything runs on the bus clock
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Bus answers
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not OKAY");
  property p_rd_wait;
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_nowait; hsel && hready && htrans[1] && hwrite |=> hreadyout; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_rd_high; hsel && hready && htrans[1] && !hwrite |=> ##1 hrdata[31:8] == 24'h0;
  endproperty
  a_rd_high: assert property (p_rd_high) else $error("upper read bits set");

  // Output clocks and register fields
  property p_stop; stop_mode[*2] |-> !osc_out_clock && !core_out_clock; endproperty
  a_stop: assert property (p_stop) else $error("clock runs in stop");
  property p_mult_nz; multiplier_factor != 7'h0; endproperty
  a_mult_nz: assert property (p_mult_nz) else $error("factor zero");
  property p_rst; !$past(hresetn) |-> multiplier_factor == 7'h15 && cap_adjust_factor == 8'h80;
  endproperty
  a_rst: assert property (p_rst) else $error("reset factors wrong");
  // Loop filter value reaches the register, then the output one edge later
  property p_halve;
    lf_update && int_osc_enable |-> ##2 dco_halving_count ==
      (($past(lf_halving_count, 2) > 4'h9) ? 4'h9 : $past(lf_halving_count, 2));
  endproperty
  a_halve: assert property (p_halve) else $error("halving load wrong");
  property p_stage;
    lf_update && int_osc_enable |-> ##2 dco_stage_count == $past(lf_stage_count, 2);
  endproperty
  a_stage: assert property (p_stage) else $error("stage load wrong");
  property p_irq_on;
    clk_mon_irq && !stop_mode && !$past(stop_mode) |-> int_osc_enable && ext_osc_enable;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq with oscillator off");

  // Main scenarios reached
  c_read: cover property (hsel && hready && htrans[1] && !hwrite);
  c_irq: cover property ($rose(clk_mon_irq));
  c_stop: cover property (stop_mode[*2]);
  c_lf: cover property (lf_update && int_osc_enable);
endmodule : icgr_top_asserts

bind icgr_top icgr_top_asserts u_icgr_top_asserts (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .stop_mode, .lf_update, .lf_halving_count,
  .lf_stage_count, .osc_out_clock, .core_out_clock, .clk_mon_irq, .int_osc_enable,
  .ext_osc_enable, .multiplier_factor, .cap_adjust_factor, .dco_halving_count,
  .dco_stage_count);

// [tb/tb.sv]
/*
 * Self-checking bench of the clock generator registers over AHB-Lite.
 * Assumes icgr_pkg and the checker are compiled first; hready is hreadyout.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module tb;
  import icgr_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_run, slow_crystal_option;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic internal_clock, external_clock, int_within_tol, stop_mode, lf_update;
  logic [3:0] lf_halving_count, dco_halving_count;
  logic [7:0] lf_stage_count, rd, cap_adjust_factor, dco_stage_count;
  logic osc_out_clock, core_out_clock, clk_mon_irq, int_osc_enable, ext_osc_enable;
  logic [6:0] multiplier_factor;
  int fail_count = 0;
  int cmp_count = 0;

  icgr_top #(.SLOW_TIMEOUT(2000)) u_icgr_top (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .internal_clock, .external_clock, .int_within_tol, .slow_crystal_option,
    .stop_mode, .lf_update, .lf_halving_count, .lf_stage_count, .osc_out_clock,
    .core_out_clock, .clk_mon_irq, .int_osc_enable, .ext_osc_enable, .multiplier_factor,
    .cap_adjust_factor, .dco_halving_count, .dco_stage_count);

  // Bus clock and the two oscillator clocks; external one stops on demand
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    internal_clock = 1'b0;
    forever #15 internal_clock = ~internal_clock;
  end
  initial begin
    external_clock = 1'b0;
    forever #10 if (ext_run) external_clock = ~external_clock;
  end

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // One single AHB transfer; read byte lands in rd
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, idx, 2'b00};
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata[7:0];
    if (n >= 100) begin
      fail_count++;
      print_verdict();
    end
  endtask : bus

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task automatic chk(input logic [5:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    `CHK(rd, e)
  endtask : chk

  // Poll control until all bits of the mask are set
  task automatic wait_ctl(input logic [7:0] m);
    int i;
    for (i = 0; i < 300; i++) begin
      bus(1'b0, IDX_CONTROL, 8'h00);
      if ((rd & m) === m) break;
      repeat (100) @(posedge hclk);
    end
    if (i == 300) begin
      fail_count++;
      print_verdict();
    end
  endtask : wait_ctl

  task automatic lf_pulse(input logic [3:0] h, input logic [7:0] s);
    @(posedge hclk);
    lf_update <= 1'b1;
    lf_halving_count <= h;
    lf_stage_count <= s;
    @(posedge hclk);
    lf_update <= 1'b0;
  endtask : lf_pulse

  task automatic reset_dut;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
  endtask : reset_dut

  // Test sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    int_within_tol = 1'b1;
    slow_crystal_option = 1'b0;
    stop_mode = 1'b0;
    lf_update = 1'b0;
    lf_halving_count = 4'h0;
    lf_stage_count = 8'h00;
    ext_run = 1'b0;
    reset_dut();
    chk(IDX_CONTROL, 8'h08);
    chk(IDX_MULT, 8'h15);
    chk(IDX_TRIM, 8'h80);
    chk(6'h3b, 8'h00);
    $display("test reset done");
    wr(IDX_MULT, 8'h80);
    chk(IDX_MULT, 8'h00);
    `CHK(multiplier_factor, 7'h01)
    wr(IDX_TRIM, 8'h7f);
    repeat (2) @(posedge hclk);
    `CHK(cap_adjust_factor, 8'h7f)
    wr(IDX_MULT, 8'h15);
    $display("test factors done");
    for (int v = 0; v < 16; v++) begin
      lf_pulse(4'(v), 8'(v * 17));
      chk(IDX_DIVIDER, 8'(v));
      `CHK(dco_halving_count, (v > 9) ? 4'h9 : 4'(v))
      `CHK(dco_stage_count, 8'(v * 17))
    end
    wr(IDX_DIVIDER, 8'h03);
    wr(IDX_STAGE, 8'h11);
    chk(IDX_DIVIDER, 8'h0f);
    chk(IDX_STAGE, 8'hff);
    $display("test loop filter done");
    wr(IDX_CONTROL, 8'h0a);
    wr(IDX_CONTROL, 8'h3a);
    chk(IDX_CONTROL, 8'h0e);
    ext_run = 1'b1;
    repeat (16000) @(posedge hclk);
    chk(IDX_CONTROL, 8'h0e);
    wait_ctl(8'h01);
    chk(IDX_CONTROL, 8'h0f);
    wr(IDX_CONTROL, 8'h02);
    chk(IDX_CONTROL, 8'h0f);
    wr(IDX_CONTROL, 8'h1a);
    chk(IDX_CONTROL, 8'h1f);
    wr(IDX_CONTROL, 8'h18);
    chk(IDX_CONTROL, 8'h1f);
    wr(IDX_CONTROL, 8'h12);
    chk(IDX_CONTROL, 8'h13);
    `CHK(int_osc_enable, 1'b0)
    wr(IDX_DIVIDER, 8'hf3);
    chk(IDX_DIVIDER, 8'h03);
    wr(IDX_CONTROL, 8'h1a);
    wait_ctl(8'h04);
    wr(IDX_CONTROL, 8'h0a);
    chk(IDX_CONTROL, 8'h0f);
    $display("test interlocks done");
    wr(IDX_CONTROL, 8'h8a);
    chk(IDX_CONTROL, 8'h0f);
    wr(IDX_CONTROL, 8'h2a);
    chk(IDX_CONTROL, 8'h2f);
    wr(IDX_CONTROL, 8'haa);
    chk(IDX_CONTROL, 8'haf);
    wr(IDX_MULT, 8'h05);
    wr(IDX_TRIM, 8'h11);
    chk(IDX_MULT, 8'h15);
    chk(IDX_TRIM, 8'h7f);
    `CHK(clk_mon_irq, 1'b0)
    slow_crystal_option <= 1'b1;
    ext_run = 1'b0;
    repeat (1000) @(posedge hclk);
    chk(IDX_CONTROL, 8'haf);
    wait_ctl(8'h40);
    repeat (2) @(posedge hclk);
    `CHK(clk_mon_irq, 1'b1)
    chk(IDX_CONTROL, 8'hee);
    ext_run = 1'b1;
    repeat (50) @(posedge hclk);
    wr(IDX_CONTROL, 8'hca);
    wr(IDX_CONTROL, 8'haa);
    chk(IDX_CONTROL, 8'hee);
    wr(IDX_CONTROL, 8'haa);
    chk(IDX_CONTROL, 8'hae);
    `CHK(clk_mon_irq, 1'b0)
    $display("test monitor done");
    @(posedge hclk);
    stop_mode <= 1'b1;
    repeat (4) @(posedge hclk);
    `CHK(osc_out_clock, 1'b0)
    `CHK(core_out_clock, 1'b0)
    stop_mode <= 1'b0;
    chk(IDX_TRIM, 8'h7f);
    reset_dut();
    chk(IDX_CONTROL, 8'h08);
    chk(IDX_MULT, 8'h15);
    chk(IDX_TRIM, 8'h80);
    chk(IDX_DIVIDER, 8'h03);
    chk(IDX_STAGE, 8'hff);
    $display("test stop and reset done");
    print_verdict();
  end
endmodule : tb
